// ==== rtl/double_increment_op_inv_and_cond_jump_unit.sv ====
// double-increment, invert and relative jump execution unit with apb registers
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "double_increment_op_inv_jump_params.svh"

module double_increment_op_inv_and_cond_jump_unit #(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic [15:0] all_ones(input logic is_byte);
		all_ones = is_byte ? `BYTE_ONES : `WORD_ONES;
	endfunction

	function automatic logic [15:0] alu_result(input double_increment_op_inv_jump_pkg::op_t op,
			input logic is_byte, input logic [15:0] dst);
		logic [15:0] r;
		r = dst;
		if (op == double_increment_op_inv_jump_pkg::OP_DOUBLE_INCREMENT_OP) begin
			r = dst + `DOUBLE_INCREMENT_OP_STEP; // see [RULE1]
		end else if (op == double_increment_op_inv_jump_pkg::OP_INV) begin
			r = dst ^ all_ones(is_byte); // see [RULE7]
		end
		// byte results clear the high byte, as a byte write to a register does
		alu_result = r & all_ones(is_byte); // see [RULE19]
	endfunction

	// returns {n, z, c, v}
	function automatic logic [3:0] alu_flags(input double_increment_op_inv_jump_pkg::op_t op,
			input logic is_byte, input logic [15:0] dst);
		logic [15:0] ones;
		logic [15:0] smax;
		logic [15:0] d;
		logic [15:0] r;
		logic n;
		logic z;
		logic c;
		logic v;
		ones = all_ones(is_byte);
		smax = is_byte ? `BYTE_SMAX : `WORD_SMAX;
		d = dst & ones;
		r = alu_result(op, is_byte, dst);
		n = is_byte ? r[7] : r[15]; // see [RULE2] [RULE19]
		if (op == double_increment_op_inv_jump_pkg::OP_DOUBLE_INCREMENT_OP) begin
			z = (d == ones - 16'h0001); // see [RULE3]
			c = (d == ones - 16'h0001) || (d == ones); // see [RULE4]
			v = (d == smax - 16'h0001) || (d == smax); // see [RULE5]
		end else begin
			z = (d == ones); // see [RULE8]
			c = !z; // see [RULE9]
			v = is_byte ? d[7] : d[15]; // see [RULE10]
		end
		alu_flags = {n, z, c, v};
	endfunction

	function automatic logic jump_taken(input double_increment_op_inv_jump_pkg::cond_t cond,
			input logic [15:0] sr);
		case (cond)
			double_increment_op_inv_jump_pkg::COND_CARRY: jump_taken = sr[`SR_C]; // see [RULE13]
			double_increment_op_inv_jump_pkg::COND_EQUAL: jump_taken = sr[`SR_Z]; // see [RULE14]
			double_increment_op_inv_jump_pkg::COND_GE: jump_taken = !(sr[`SR_N] ^ sr[`SR_V]); // see [RULE15]
			double_increment_op_inv_jump_pkg::COND_LESS: jump_taken = sr[`SR_N] ^ sr[`SR_V]; // see [RULE16]
			double_increment_op_inv_jump_pkg::COND_ALWAYS: jump_taken = 1'b1; // see [RULE12]
			double_increment_op_inv_jump_pkg::COND_NEG: jump_taken = sr[`SR_N]; // see [RULE17]
			default: jump_taken = 1'b0;
		endcase
	endfunction

	// offset spans -512..+511 words from the program counter
	function automatic logic [15:0] jump_target(input logic [15:0] pc, input logic [15:0] instr);
		jump_target = pc + {{5{instr[`OFFSET_MSB]}}, instr[`OFFSET_MSB:0], 1'b0}; // see [RULE11]
	endfunction

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		addr_hit = (a == `OFS_DST) || (a == `OFS_STATUS) || (a == `OFS_PC) ||
			(a == `OFS_INSTR) || (a == `OFS_CMD);
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	double_increment_op_inv_jump_pkg::state_t state_ff;
	double_increment_op_inv_jump_pkg::op_t cmd_op_ff;
	double_increment_op_inv_jump_pkg::cond_t cmd_cond_ff;
	logic cmd_byte_ff;
	logic [15:0] dst_ff;
	logic [15:0] sr_ff;
	logic [15:0] pc_ff;
	logic [15:0] instr_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic is_exec;
	logic acc_done;
	logic wr_ok;
	logic [3:0] nxt_flags;
	logic [15:0] nxt_result;
	logic nxt_taken;
	logic [31:0] rd_mux;

	assign is_exec = (state_ff == double_increment_op_inv_jump_pkg::ST_EXEC);
	assign acc_done = psel && penable && pready_ff;
	assign wr_ok = acc_done && pwrite && !pslverr_ff;
	assign nxt_result = alu_result(cmd_op_ff, cmd_byte_ff, dst_ff);
	assign nxt_flags = alu_flags(cmd_op_ff, cmd_byte_ff, dst_ff);
	assign nxt_taken = jump_taken(cmd_cond_ff, sr_ff);

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			`OFS_DST: rd_mux = {16'h0000, dst_ff};
			`OFS_STATUS: rd_mux = {16'h0000, sr_ff};
			`OFS_PC: rd_mux = {16'h0000, pc_ff};
			`OFS_INSTR: rd_mux = {16'h0000, instr_ff};
			`OFS_CMD: rd_mux = {25'h0000000, cmd_cond_ff, 1'b0, cmd_byte_ff, cmd_op_ff};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// apb slave: ready in the first access cycle, held off while an operation executes
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= psel && !pready_ff && !is_exec;
			if (psel && !pready_ff && !is_exec) begin
				pslverr_ff <= !addr_hit(paddr);
				prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
			end else begin
				pslverr_ff <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// command capture and sequencing
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= double_increment_op_inv_jump_pkg::ST_IDLE;
			cmd_op_ff <= double_increment_op_inv_jump_pkg::OP_NONE;
			cmd_cond_ff <= double_increment_op_inv_jump_pkg::COND_CARRY;
			cmd_byte_ff <= 1'b0;
		end else begin
			case (state_ff)
				double_increment_op_inv_jump_pkg::ST_IDLE: begin
					if (wr_ok && paddr == `OFS_CMD) begin
						cmd_op_ff <= double_increment_op_inv_jump_pkg::op_t'(pwdata[`CMD_OP_MSB:`CMD_OP_LSB]);
						cmd_cond_ff <= double_increment_op_inv_jump_pkg::cond_t'(pwdata[`CMD_COND_MSB:`CMD_COND_LSB]);
						cmd_byte_ff <= pwdata[`CMD_BYTE];
						if (pwdata[`CMD_OP_MSB:`CMD_OP_LSB] != double_increment_op_inv_jump_pkg::OP_NONE) begin
							state_ff <= double_increment_op_inv_jump_pkg::ST_EXEC;
						end
					end
				end
				double_increment_op_inv_jump_pkg::ST_EXEC: state_ff <= double_increment_op_inv_jump_pkg::ST_IDLE;
				default: state_ff <= double_increment_op_inv_jump_pkg::ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// destination operand
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dst_ff <= `RST_DST;
		end else if (is_exec && cmd_op_ff != double_increment_op_inv_jump_pkg::OP_JUMP) begin
			dst_ff <= nxt_result; // see [RULE1] [RULE7]
		end else if (wr_ok && paddr == `OFS_DST) begin
			dst_ff <= pwdata[15:0];
		end
	end

	// ------------------------------------------------------------
	// status register: only n, z, c, v move on execution
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sr_ff <= `RST_STATUS;
		end else if (is_exec && cmd_op_ff != double_increment_op_inv_jump_pkg::OP_JUMP) begin
			// mode bits keep their value, see [RULE6]; jumps never enter here, see [RULE18]
			sr_ff[`SR_N] <= nxt_flags[3];
			sr_ff[`SR_Z] <= nxt_flags[2];
			sr_ff[`SR_C] <= nxt_flags[1];
			sr_ff[`SR_V] <= nxt_flags[0];
		end else if (wr_ok && paddr == `OFS_STATUS) begin
			sr_ff <= pwdata[15:0];
		end
	end

	// ------------------------------------------------------------
	// program counter and jump word
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_ff <= `RST_PC;
		end else if (is_exec && cmd_op_ff == double_increment_op_inv_jump_pkg::OP_JUMP) begin
			// pc already points past the jump, so not taken leaves it as is
			if (nxt_taken) begin
				pc_ff <= jump_target(pc_ff, instr_ff); // see [RULE11]
			end
		end else if (wr_ok && paddr == `OFS_PC) begin
			pc_ff <= {pwdata[15:1], 1'b0};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_ff <= `RST_INSTR;
		end else if (wr_ok && paddr == `OFS_INSTR) begin
			instr_ff <= pwdata[15:0];
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic ex_double_increment_op_w;
	logic ex_inv;
	logic ex_jump;
	assign ex_double_increment_op_w = is_exec && cmd_op_ff == double_increment_op_inv_jump_pkg::OP_DOUBLE_INCREMENT_OP && !cmd_byte_ff;
	assign ex_inv = is_exec && cmd_op_ff == double_increment_op_inv_jump_pkg::OP_INV;
	assign ex_jump = is_exec && cmd_op_ff == double_increment_op_inv_jump_pkg::OP_JUMP;
	logic ex_double_increment_op_b;
	logic [15:0] pc_taken;
	assign ex_double_increment_op_b = is_exec && cmd_op_ff == double_increment_op_inv_jump_pkg::OP_DOUBLE_INCREMENT_OP && cmd_byte_ff;
	assign pc_taken = pc_ff + {{5{instr_ff[9]}}, instr_ff[9:0], 1'b0};

	property p_double_increment_op_sum;
		ex_double_increment_op_w |=> dst_ff == $past(dst_ff) + `DOUBLE_INCREMENT_OP_STEP;
	endproperty
	a_double_increment_op_sum: assert property (p_double_increment_op_sum) else $error("double increment sum wrong"); // see [RULE1]

	property p_double_increment_op_neg;
		ex_double_increment_op_w |=> sr_ff[`SR_N] == dst_ff[15];
	endproperty
	a_double_increment_op_neg: assert property (p_double_increment_op_neg) else $error("negative flag wrong"); // see [RULE2]

	property p_double_increment_op_zero;
		ex_double_increment_op_w |=> sr_ff[`SR_Z] == ($past(dst_ff) == 16'hFFFE);
	endproperty
	a_double_increment_op_zero: assert property (p_double_increment_op_zero) else $error("double_increment_op zero flag wrong"); // see [RULE3]

	property p_double_increment_op_carry;
		ex_double_increment_op_w |=> sr_ff[`SR_C] == ($past(dst_ff) >= 16'hFFFE);
	endproperty
	a_double_increment_op_carry: assert property (p_double_increment_op_carry) else $error("double_increment_op carry wrong"); // see [RULE4]

	property p_double_increment_op_ovf;
		ex_double_increment_op_w |=> sr_ff[`SR_V] == ($past(dst_ff) == 16'h7FFE || $past(dst_ff) == 16'h7FFF);
	endproperty
	a_double_increment_op_ovf: assert property (p_double_increment_op_ovf) else $error("double_increment_op overflow wrong"); // see [RULE5]

	property p_mode_keep;
		is_exec |=> sr_ff[`SR_OSCILLATOR_OFF_BIT:`SR_GIE] == $past(sr_ff[`SR_OSCILLATOR_OFF_BIT:`SR_GIE]);
	endproperty
	a_mode_keep: assert property (p_mode_keep) else $error("mode bits changed"); // see [RULE6]

	property p_inv_value;
		ex_inv |=> dst_ff == (~$past(dst_ff) & ($past(cmd_byte_ff) ? 16'h00FF : 16'hFFFF));
	endproperty
	a_inv_value: assert property (p_inv_value) else $error("invert result wrong"); // see [RULE7]

	property p_inv_zc;
		ex_inv |=> sr_ff[`SR_C] == !sr_ff[`SR_Z] && sr_ff[`SR_Z] == (dst_ff == 16'h0000);
	endproperty
	a_inv_zc: assert property (p_inv_zc) else $error("invert zero or carry wrong"); // see [RULE9]

	property p_jump_target;
		ex_jump && nxt_taken |=>
			pc_ff == $past(pc_ff) + {{5{$past(instr_ff[9])}}, $past(instr_ff[9:0]), 1'b0};
	endproperty
	a_jump_target: assert property (p_jump_target) else $error("jump target wrong"); // see [RULE11]

	property p_jump_less;
		ex_jump && cmd_cond_ff == double_increment_op_inv_jump_pkg::COND_LESS |=>
			(pc_ff != $past(pc_ff)) || ($past(sr_ff[`SR_N]) == $past(sr_ff[`SR_V]))
			|| ($past(instr_ff[9:0]) == 10'h000);
	endproperty
	a_jump_less: assert property (p_jump_less) else $error("signed less not taken"); // see [RULE16]

	property p_jump_flags;
		ex_jump |=> sr_ff == $past(sr_ff) && dst_ff == $past(dst_ff);
	endproperty
	a_jump_flags: assert property (p_jump_flags) else $error("jump changed flags"); // see [RULE18]

	property p_double_increment_op_byte;
		ex_double_increment_op_b |=> dst_ff == {8'h00, $past(dst_ff[7:0]) + 8'h02};
	endproperty
	a_double_increment_op_byte: assert property (p_double_increment_op_byte) else $error("byte increment wrong"); // see [RULE19]

	property p_double_increment_op_byte_carry;
		ex_double_increment_op_b |=> sr_ff[`SR_C] == ($past(dst_ff[7:0]) >= 8'hFE);
	endproperty
	a_double_increment_op_byte_carry: assert property (p_double_increment_op_byte_carry) else $error("byte carry wrong"); // see [RULE19]

	property p_inv_neg;
		ex_inv |=> sr_ff[`SR_N] == ($past(cmd_byte_ff) ? dst_ff[7] : dst_ff[15]);
	endproperty
	a_inv_neg: assert property (p_inv_neg) else $error("invert negative wrong"); // see [RULE2]

	property p_inv_zero;
		ex_inv |=> sr_ff[`SR_Z] ==
			($past(cmd_byte_ff) ? $past(dst_ff[7:0]) == 8'hFF : $past(dst_ff) == 16'hFFFF);
	endproperty
	a_inv_zero: assert property (p_inv_zero) else $error("invert zero wrong"); // see [RULE8]

	property p_inv_ovf;
		ex_inv |=> sr_ff[`SR_V] == ($past(cmd_byte_ff) ? $past(dst_ff[7]) : $past(dst_ff[15]));
	endproperty
	a_inv_ovf: assert property (p_inv_ovf) else $error("invert overflow wrong"); // see [RULE10]

	property p_jump_carry;
		ex_jump && cmd_cond_ff == double_increment_op_inv_jump_pkg::COND_CARRY |=>
			pc_ff == ($past(sr_ff[`SR_C]) ? $past(pc_taken) : $past(pc_ff));
	endproperty
	a_jump_carry: assert property (p_jump_carry) else $error("carry jump wrong"); // see [RULE13]

	property p_jump_equal;
		ex_jump && cmd_cond_ff == double_increment_op_inv_jump_pkg::COND_EQUAL |=>
			pc_ff == ($past(sr_ff[`SR_Z]) ? $past(pc_taken) : $past(pc_ff));
	endproperty
	a_jump_equal: assert property (p_jump_equal) else $error("equal jump wrong"); // see [RULE14]

	property p_jump_ge;
		ex_jump && cmd_cond_ff == double_increment_op_inv_jump_pkg::COND_GE |=>
			pc_ff == (($past(sr_ff[`SR_N]) == $past(sr_ff[`SR_V])) ? $past(pc_taken) : $past(pc_ff));
	endproperty
	a_jump_ge: assert property (p_jump_ge) else $error("signed ge jump wrong"); // see [RULE15]

	property p_jump_neg;
		ex_jump && cmd_cond_ff == double_increment_op_inv_jump_pkg::COND_NEG |=>
			pc_ff == ($past(sr_ff[`SR_N]) ? $past(pc_taken) : $past(pc_ff));
	endproperty
	a_jump_neg: assert property (p_jump_neg) else $error("negative jump wrong"); // see [RULE17]

	property p_jump_always;
		ex_jump && cmd_cond_ff == double_increment_op_inv_jump_pkg::COND_ALWAYS |=>
			pc_ff == $past(pc_taken);
	endproperty
	a_jump_always: assert property (p_jump_always) else $error("jump not taken"); // see [RULE12]

	// ready must be a single-cycle pulse or the master would see two transfers
	property p_ready_pulse;
		pready_ff |=> !pready_ff;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

	property p_err_ready;
		pslverr_ff |-> pready_ff;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");

	property p_exec_stall;
		is_exec |-> !pready_ff;
	endproperty
	a_exec_stall: assert property (p_exec_stall) else $error("bus answered during execution");

	c_double_increment_op_wrap: cover property (ex_double_increment_op_w && dst_ff == 16'hFFFE);
	c_inv_byte: cover property (ex_inv && cmd_byte_ff);
	c_jump_back: cover property (ex_jump && nxt_taken && instr_ff[9]);
	c_jump_skip: cover property (ex_jump && !nxt_taken);
	c_double_increment_op_byte: cover property (ex_double_increment_op_b && dst_ff[7:0] == 8'hFF);

endmodule

`default_nettype wire

// ==== rtl/double_increment_op_inv_jump_params.svh ====
// offsets, field positions, reset values and constants of the execution unit
// Notes on behaviour
// [RULE1] double-increment adds two to destination and writes it back, word or byte
// [RULE2] negative flag follows result sign bit for double-increment and invert
// [RULE3] word double-increment sets zero only when operand was FFFE
// [RULE4] word double-increment sets carry when operand was FFFE or FFFF
// [RULE5] word double-increment sets overflow when operand was 7FFE or 7FFF
// [RULE6] oscillator-off, processor-off and interrupt-enable bits stay unchanged
// [RULE7] invert writes the bitwise complement of the destination
// [RULE8] invert sets zero only when operand was all ones
// [RULE9] invert carry is set when result non-zero, the complement of zero
// [RULE10] invert overflow is set when original operand was negative
// [RULE11] taken jump adds sign-extended 10-bit offset times two to program counter
// [RULE12] unconditional jump always taken, reach -512 to +511 words
// [RULE13] jump on carry branches when carry is one, else falls through
// [RULE14] jump on equal branches when zero flag is one, else falls through
// [RULE15] signed greater-equal branches when negative xor overflow is zero
// [RULE16] signed less branches when negative xor overflow is one
// [RULE17] jump on negative branches when negative flag is one
// [RULE18] jumps never change negative, zero, carry or overflow flags
// [RULE19] byte forms work on low eight bits with bit 7 as sign
`ifndef DOUBLE_INCREMENT_OP_INV_JUMP_PARAMS_SVH
`define DOUBLE_INCREMENT_OP_INV_JUMP_PARAMS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_DST 8'h00
`define OFS_STATUS 8'h04
`define OFS_PC 8'h08
`define OFS_INSTR 8'h0C
`define OFS_CMD 8'h10

// ------------------------------------------------------------
// status register bit positions
// ------------------------------------------------------------
`define SR_C 0
`define SR_Z 1
`define SR_N 2
`define SR_GIE 3
`define SR_PROCESSOR_OFF_BIT 4
`define SR_OSCILLATOR_OFF_BIT 5
`define SR_V 8

// ------------------------------------------------------------
// command register fields
// ------------------------------------------------------------
`define CMD_OP_LSB 0
`define CMD_OP_MSB 1
`define CMD_BYTE 2
`define CMD_COND_LSB 4
`define CMD_COND_MSB 6

// ------------------------------------------------------------
// reset values and operand constants
// ------------------------------------------------------------
`define RST_DST 16'h0000
`define RST_STATUS 16'h0000
`define RST_PC 16'h0000
`define RST_INSTR 16'h0000
`define DOUBLE_INCREMENT_OP_STEP 16'h0002
`define WORD_ONES 16'hFFFF
`define BYTE_ONES 16'h00FF
`define WORD_SMAX 16'h7FFF
`define BYTE_SMAX 16'h007F
`define OFFSET_MSB 9

`endif

// ==== rtl/double_increment_op_inv_jump_pkg.sv ====
// types of the execution unit
package double_increment_op_inv_jump_pkg;

	typedef enum logic [1:0] {
		OP_NONE = 2'h0,
		OP_DOUBLE_INCREMENT_OP = 2'h1,
		OP_INV = 2'h2,
		OP_JUMP = 2'h3
	} op_t;

	typedef enum logic [2:0] {
		COND_CARRY = 3'h0,
		COND_EQUAL = 3'h1,
		COND_GE = 3'h2,
		COND_LESS = 3'h3,
		COND_ALWAYS = 3'h4,
		COND_NEG = 3'h5
	} cond_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} state_t;

endpackage

// ==== tb/double_increment_op_inv_and_cond_jump_unit_tb_top.sv ====
// self-checking bench for the double-increment, invert and jump unit
`timescale 1ns/1ps
`default_nettype none
`include "double_increment_op_inv_jump_params.svh"

module double_increment_op_inv_and_cond_jump_unit_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	int error_cnt = 0;
	int n_compared = 0;
	logic [15:0] vals [12] = '{16'h0000, 16'h007E, 16'h007F, 16'h00FE, 16'h00FF, 16'h7FFE,
		16'h7FFF, 16'h8000, 16'hFFFE, 16'hFFFF, 16'h12AE, 16'hA57F};
	// both ends of the offset range plus small steps either way
	logic [9:0] offs [4] = '{10'h1FF, 10'h200, 10'h001, 10'h3FF};

	always #12.5 pclk = ~pclk;

	double_increment_op_inv_and_cond_jump_unit u_double_increment_op_inv_and_cond_jump_unit (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr)
	);

	// ------------------------------------------------------------
	// reporting
	// ------------------------------------------------------------
	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", nm, exp, got);
			error_cnt++;
		end
	endtask

	// ------------------------------------------------------------
	// apb master
	// ------------------------------------------------------------
	// request held until pready is seen high, no fixed wait assumed
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		chk("pready", 32'h1, {31'h0, pready});
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] rd;
		logic err;
		apb(1'b1, a, {16'h0000, d}, rd, err);
		chk("write_err", 32'h0, {31'h0, err});
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] exp);
		logic [31:0] rd;
		logic err;
		apb(1'b0, a, 32'h0, rd, err);
		chk(nm, {16'h0000, exp}, rd);
		chk("read_err", 32'h0, {31'h0, err});
	endtask

	// ------------------------------------------------------------
	// reference for double-increment and invert
	// ------------------------------------------------------------
	// f is {v, n, z, c}
	function automatic void model(input logic inv, input logic bt, input logic [15:0] d,
		output logic [15:0] r, output logic [3:0] f);
		logic [15:0] m;
		logic [15:0] s;
		m = bt ? 16'h00FF : 16'hFFFF;
		s = bt ? 16'h0080 : 16'h8000;
		r = inv ? (~d & m) : ((d + 16'h0002) & m);
		f[2] = (r & s) != 16'h0000;
		if (inv) begin
			f[1] = (d & m) == m;
			f[0] = r != 16'h0000;
			f[3] = (d & s) != 16'h0000;
		end else begin
			f[1] = (d & m) == (m - 16'h0001);
			f[0] = (d & m) >= (m - 16'h0001);
			f[3] = (d & m) == (s - 16'h0002) || (d & m) == (s - 16'h0001);
		end
	endfunction

	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		end_sim();
	end

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		logic [15:0] r;
		logic [3:0] f;
		logic [15:0] st;
		logic [2:0] cd;
		logic [9:0] off;
		logic tk;
		logic [15:0] pc_exp;
		logic [31:0] rd;
		logic err;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("dst_reset", `OFS_DST, `RST_DST);
		rd_chk("status_reset", `OFS_STATUS, `RST_STATUS);
		rd_chk("pc_reset", `OFS_PC, `RST_PC);
		rd_chk("instr_reset", `OFS_INSTR, `RST_INSTR);
		// flags preset to the opposite of the expected result, mode bits set
		for (int i = 0; i < 12; i++) begin
			for (int k = 0; k < 4; k++) begin
				model(k[1], k[0], vals[i], r, f);
				st = 16'h0038 | {7'h00, ~f[3], 5'h00, ~f[2], ~f[1], ~f[0]};
				wr(`OFS_DST, vals[i]);
				wr(`OFS_STATUS, st);
				wr(`OFS_CMD, {9'h000, 3'h0, 1'b0, k[0],
					k[1] ? double_increment_op_inv_jump_pkg::OP_INV : double_increment_op_inv_jump_pkg::OP_DOUBLE_INCREMENT_OP});
				rd_chk("result", `OFS_DST, r);
				st = 16'h0038 | {7'h00, f[3], 5'h00, f[2:0]};
				if (k[1]) begin
					rd_chk("inv_flags", `OFS_STATUS, st);
				end else begin
					rd_chk("double_increment_op_flags", `OFS_STATUS, st);
				end
			end
		end
		wr(`OFS_DST, 16'h5A3C);
		for (int c = 0; c < 8; c++) begin
			for (int p = 0; p < 16; p++) begin
				cd = c[2:0];
				off = offs[p % 4];
				case (cd)
					double_increment_op_inv_jump_pkg::COND_CARRY: tk = p[0];
					double_increment_op_inv_jump_pkg::COND_EQUAL: tk = p[1];
					double_increment_op_inv_jump_pkg::COND_GE: tk = ~(p[2] ^ p[3]);
					double_increment_op_inv_jump_pkg::COND_LESS: tk = p[2] ^ p[3];
					double_increment_op_inv_jump_pkg::COND_ALWAYS: tk = 1'b1;
					double_increment_op_inv_jump_pkg::COND_NEG: tk = p[2];
					default: tk = 1'b0;
				endcase
				st = 16'h0038 | {7'h00, p[3], 5'h00, p[2:0]};
				wr(`OFS_PC, 16'h4001);
				// upper instruction bits set to prove only the offset field counts
				wr(`OFS_INSTR, 16'hFC00 | {6'h00, off});
				wr(`OFS_STATUS, st);
				wr(`OFS_CMD, {9'h000, cd, 1'b0, 1'b0, double_increment_op_inv_jump_pkg::OP_JUMP});
				pc_exp = tk ? 16'h4000 + {{5{off[9]}}, off, 1'b0} : 16'h4000;
				rd_chk("pc", `OFS_PC, pc_exp);
				rd_chk("jump_flags", `OFS_STATUS, st);
				rd_chk("jump_dst", `OFS_DST, 16'h5A3C);
			end
		end
		apb(1'b0, 8'h14, 32'h0, rd, err);
		chk("unmapped_err", 32'h1, {31'h0, err});
		chk("unmapped_data", 32'h0, rd);
		apb(1'b1, 8'h20, 32'h0000FFFF, rd, err);
		chk("unmapped_wr_err", 32'h1, {31'h0, err});
		rd_chk("dst_kept", `OFS_DST, 16'h5A3C);
		end_sim();
	end
endmodule

`default_nettype wire
